// ### rtl/mcsj_top.sv
// Operation
// - Echo bit puts GPIO 1,2 in frame
// - Digital loopback feeds receive into transmit
// - Analog loopback routes transmit to receive
// - Writing one to bit 4 soft-resets
// - Bit 3 powers down oscillator DAC
// - Bit 2 powers down receive channel
// - Bit 1 powers down transmit channel
// - Bit 0 powers down main reference
// - Other power-downs leave reference running
// - Master control resets to all zeros
// - Sample clock divides by half the default ratio
// - Ratio plus delta shifts sample phase
// - Digital loop mode halves sample clock
// - DAC clock jitters with ADC clock
// - Delta applied repeat periods after delay
// - Each armed sequence runs once only
// - Serial clock pulse has fixed shape
// - Sixteen serial clocks, idle until edge
// - Only delay write arms; it reads zero
// - Delay counts periods; zero, one invalid
// - Zero delta or repeat gives no jitter
`timescale 1ns/1ps
`include "mcsj_cfg.svh"
module mcsj_top (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire mcsj_pkg::mcsj_req_s     reg_req,
  input  wire logic [1:0]              gpio_in,
  input  wire logic                    dpll_mode_pin,
  output logic [`MCSJ_DATA_W-1:0]      rd_data,
  output logic [1:0]                   gpio_echo,
  output logic                         gpio_echo_enable,
  output logic                         digital_loopback_enable,
  output logic                         analog_loopback_enable,
  output logic                         soft_reset,
  output logic                         oscillator_dac_powerdown,
  output logic                         receive_powerdown,
  output logic                         transmit_powerdown,
  output logic                         soft_reference_powerdown,
  output logic                         adc_sample_clock,
  output logic                         dac_sample_clock,
  output logic                         serial_clk
);
  import mcsj_pkg::*;

  // Module state except the reset release chain
  typedef struct packed {
    mcsj_mctl_s mctl;        // Master control
    logic [7:0] def_ratio;   // Default divide ratio
    logic [3:0] delta;       // Signed ratio delta
    logic [3:0] rpt;         // Repeat count
    mcsj_jit_e  jit;         // Jitter sequencer
    logic [7:0] delay_left;  // Periods before jitter
    logic [3:0] rep_left;    // Jittered periods left
    logic [7:0] cnt;         // Divider count
    logic [7:0] cur_ratio;   // Ratio of this period
    logic       adc;         // Sample clock
    logic       dac;         // Converter clock
    logic       sclk;        // Serial clock
    logic [4:0] burst_left;  // Serial clocks left
    logic [1:0] ph;          // Serial clock phase
    logic [2:0] srst_cnt;    // Soft reset timer
    logic [1:0] gpio_s1;     // Pin sync stage one
    logic [1:0] gpio_s2;     // Pin sync stage two
    logic       dpll_s1;     // Mode sync stage one
    logic       dpll_s2;     // Mode sync stage two
    logic [1:0] echo;        // Echoed GPIO bits
    logic [7:0] rd;          // Read data
  } mcsj_state_s;

  mcsj_state_s q;            // Current state
  mcsj_state_s next_q;       // Next state
  logic [1:0]  rst_sync;     // Reset release chain
  logic        rst_n_s;      // Synchronised reset
  logic        wrap;         // Last count of period
  logic [7:0]  jit_ratio;    // Default plus delta
  logic [7:0]  half;         // Half of period
  logic [7:0]  quarter;      // Quarter of period
  logic        wr_mctl;      // Master control write
  logic        wr_delay;     // Delay register write

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync[1];

  // Decodes and divider helpers
  assign wrap      = (q.cnt + 8'h01) >= q.cur_ratio;
  assign jit_ratio = q.def_ratio + {{4{q.delta[3]}}, q.delta};
  assign wr_mctl   = reg_req.wr && reg_req.addr == `MCSJ_OFF_MCTL;
  assign wr_delay  = reg_req.wr && reg_req.addr == `MCSJ_OFF_DELAY;

  // Next state
  always_comb begin
    next_q = q;
    // Pin synchronisers
    next_q.gpio_s1 = gpio_in;
    next_q.gpio_s2 = q.gpio_s1;
    next_q.dpll_s1 = dpll_mode_pin;
    next_q.dpll_s2 = q.dpll_s1;
    // Echo GPIO into frame only when enabled
    next_q.echo = q.mctl.gpio_echo_enable ? q.gpio_s2 : 2'h0;

    // Divider period and jitter sequence
    if (wrap) begin
      next_q.cnt = 8'h00;
      unique case (q.jit)
        JIT_IDLE: begin
          next_q.cur_ratio = q.def_ratio;
        end
        JIT_WAIT: begin
          // Delay counts whole divider periods
          if (q.delay_left == 8'h00) begin
            next_q.cur_ratio = jit_ratio;
            next_q.rep_left  = q.rep_left - 4'h1;
            next_q.jit       = JIT_RUN;
          end else begin
            next_q.delay_left = q.delay_left - 8'h01;
            next_q.cur_ratio  = q.def_ratio;
          end
        end
        JIT_RUN: begin
          if (q.rep_left != 4'h0) begin
            next_q.cur_ratio = jit_ratio;
            next_q.rep_left  = q.rep_left - 4'h1;
          end else begin
            // One shot: back to default until rearmed
            next_q.cur_ratio = q.def_ratio;
            next_q.jit       = JIT_IDLE;
          end
        end
      endcase
      // New burst at sample clock rise
      next_q.burst_left = `MCSJ_BURST_LEN;
      next_q.ph = `MCSJ_SCLK_HI_CYC + `MCSJ_SCLK_LO_CYC - 2'h1;
    end else begin
      next_q.cnt = q.cnt + 8'h01;
    end

    // Split points of the period now starting or running
    half    = next_q.cur_ratio >> 1;
    quarter = next_q.cur_ratio >> 2;
    // Sample clocks from the same count, so both jitter
    next_q.dac = (next_q.cnt < quarter) ||
                 (next_q.cnt >= half && next_q.cnt < half + quarter);
    next_q.adc = q.dpll_s2 ? (next_q.cnt < half) : next_q.dac;

    // Serial clock burst, fixed high and low
    if (!wrap && q.burst_left != 5'h00) begin
      if (q.ph == 2'h0) begin
        next_q.ph = `MCSJ_SCLK_HI_CYC + `MCSJ_SCLK_LO_CYC - 2'h1;
        next_q.burst_left = q.burst_left - 5'h01;
      end else begin
        next_q.ph = q.ph - 2'h1;
      end
    end
    // High while phase in upper part, quiet when burst done
    next_q.sclk = (q.burst_left != 5'h00) && (q.ph >= `MCSJ_SCLK_LO_CYC);

    // Register writes, ignored during soft reset
    if (reg_req.wr && q.srst_cnt == 3'h0) begin
      unique case (reg_req.addr)
        `MCSJ_OFF_MCTL: begin
          next_q.mctl = mcsj_mctl_s'(reg_req.wdata);
          // Writing one starts soft reset
          if (reg_req.wdata[`MCSJ_SRST_BIT]) begin
            next_q.srst_cnt = `MCSJ_SRST_CYC;
          end
        end
        `MCSJ_OFF_DEF: begin
          next_q.def_ratio = reg_req.wdata;
        end
        `MCSJ_OFF_DELTA: begin
          next_q.delta = reg_req.wdata[`MCSJ_DELTA_FLD];
          next_q.rpt   = reg_req.wdata[`MCSJ_RPT_FLD];
        end
        `MCSJ_OFF_DELAY: begin
          // Only this write arms, and only with delta and repeat
          if (q.delta != 4'h0 && q.rpt != 4'h0) begin
            next_q.jit        = JIT_WAIT;
            next_q.rep_left   = q.rpt;
            next_q.delay_left = (reg_req.wdata <= 8'h01) ?
                                8'h00 : reg_req.wdata - 8'h01;
          end
        end
        default: begin
          // Unmapped offsets ignored
        end
      endcase
    end

    // Soft reset returns registers to defaults
    if (q.srst_cnt != 3'h0) begin
      next_q.srst_cnt  = q.srst_cnt - 3'h1;
      next_q.mctl      = mcsj_mctl_s'(`MCSJ_MCTL_RST);
      next_q.def_ratio = `MCSJ_DEF_RST;
      next_q.delta     = `MCSJ_DELTA_RST;
      next_q.rpt       = `MCSJ_RPT_RST;
      next_q.jit       = JIT_IDLE;
    end
    // Bit reads one until soft reset is over
    next_q.mctl.soft_reset_bit = next_q.srst_cnt != 3'h0;

    // Read data; delay register keeps nothing
    unique case (reg_req.addr)
      `MCSJ_OFF_MCTL:  next_q.rd = q.mctl;
      `MCSJ_OFF_DEF:   next_q.rd = q.def_ratio;
      `MCSJ_OFF_DELTA: next_q.rd = {q.delta, q.rpt};
      default:         next_q.rd = 8'h00;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      q <= '0;
      q.mctl <= mcsj_mctl_s'(`MCSJ_MCTL_RST);
      q.def_ratio <= `MCSJ_DEF_RST;
      q.cur_ratio <= `MCSJ_DEF_RST;
      q.jit <= JIT_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from state flops
  assign rd_data                  = q.rd;
  assign gpio_echo                = q.echo;
  assign gpio_echo_enable         = q.mctl.gpio_echo_enable;
  assign digital_loopback_enable  = q.mctl.digital_loopback_enable;
  assign analog_loopback_enable   = q.mctl.analog_loopback_enable;
  assign soft_reset               = q.mctl.soft_reset_bit;
  assign oscillator_dac_powerdown = q.mctl.oscillator_dac_powerdown;
  assign receive_powerdown        = q.mctl.receive_powerdown;
  assign transmit_powerdown       = q.mctl.transmit_powerdown;
  assign soft_reference_powerdown = q.mctl.soft_reference_powerdown;
  assign adc_sample_clock         = q.adc;
  assign dac_sample_clock         = q.dac;
  assign serial_clk               = q.sclk;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  // Master control clear after reset release
  property p_mctl_rst;
    $rose(rst_n_s) |-> q.mctl == mcsj_mctl_s'(`MCSJ_MCTL_RST);
  endproperty
  a_mctl_rst: assert property (p_mctl_rst) else $error("master control not zero");

  // Echo stays zero while disabled
  property p_echo;
    !q.mctl.gpio_echo_enable |=> gpio_echo == 2'h0;
  endproperty
  a_echo: assert property (p_echo) else $error("echo leak");

  // Soft reset pulses then the bit clears
  property p_srst;
    wr_mctl && reg_req.wdata[`MCSJ_SRST_BIT] && q.srst_cnt == 3'h0
      |=> soft_reset [*4] ##1 !soft_reset;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset shape");

  // Oscillator DAC down keeps reference up
  property p_ref;
    wr_mctl && q.srst_cnt == 3'h0 && reg_req.wdata[3:0] == 4'h8
      |=> oscillator_dac_powerdown && !soft_reference_powerdown;
  endproperty
  a_ref: assert property (p_ref) else $error("reference dropped");

  // Idle divider takes default ratio
  property p_def;
    wrap && q.jit == JIT_IDLE && !wr_delay && q.srst_cnt == 3'h0
      |=> q.cur_ratio == $past(q.def_ratio);
  endproperty
  a_def: assert property (p_def) else $error("ratio not default");

  // Running sequence uses ratio plus delta
  property p_jit;
    wrap && q.jit == JIT_RUN && q.rep_left != 4'h0 && q.srst_cnt == 3'h0
      |=> q.cur_ratio == $past(jit_ratio);
  endproperty
  a_jit: assert property (p_jit) else $error("jitter ratio");

  // Zero delta never arms
  property p_nodelta;
    wr_delay && q.jit == JIT_IDLE && q.delta == 4'h0 |=> q.jit == JIT_IDLE;
  endproperty
  a_nodelta: assert property (p_nodelta) else $error("armed with zero");

  // Idle sequencer stays idle without a delay write
  property p_once;
    q.jit == JIT_IDLE && !wr_delay |=> q.jit == JIT_IDLE;
  endproperty
  a_once: assert property (p_once) else $error("rerun");

  // Serial clock high one cycle then low
  property p_sclk;
    $rose(serial_clk) |=> !serial_clk;
  endproperty
  a_sclk: assert property (p_sclk) else $error("sclk shape");

  // Quiet once the burst has ended
  property p_quiet;
    q.burst_left == 5'h00 |=> !serial_clk;
  endproperty
  a_quiet: assert property (p_quiet) else $error("sclk toggles");

  // Converter clock rises with the sample clock
  property p_dac;
    // A mode change mid-period may raise the sample clock alone
    $rose(adc_sample_clock) && $past(q.dpll_s2) == $past(q.dpll_s2, 2)
      |-> $rose(dac_sample_clock);
  endproperty
  a_dac: assert property (p_dac) else $error("dac misaligned");

  // Delay register reads zero
  property p_rd0;
    reg_req.addr == `MCSJ_OFF_DELAY |=> rd_data == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("delay retained");

  // Main scenarios
  property p_c_arm;
    q.jit == JIT_WAIT ##[1:300] q.jit == JIT_RUN;
  endproperty
  c_arm: cover property (p_c_arm);
  property p_c_done;
    q.jit == JIT_RUN ##1 q.jit == JIT_IDLE;
  endproperty
  c_done: cover property (p_c_done);
  property p_c_srst;
    $fell(soft_reset);
  endproperty
  c_srst: cover property (p_c_srst);
endmodule

// ### rtl/mcsj_cfg.svh
`ifndef MCSJ_CFG_SVH
`define MCSJ_CFG_SVH
// Register port widths
`define MCSJ_ADDR_W 5
`define MCSJ_DATA_W 8
// Register offsets
`define MCSJ_OFF_MCTL 5'h0F
`define MCSJ_OFF_DELTA 5'h0E
`define MCSJ_OFF_DELAY 5'h0D
`define MCSJ_OFF_DEF 5'h0C
// Reset values
`define MCSJ_MCTL_RST 8'h00
`define MCSJ_DEF_RST 8'h40
`define MCSJ_DELTA_RST 4'h0
`define MCSJ_RPT_RST 4'h0
// Field positions in written bytes
`define MCSJ_SRST_BIT 4
`define MCSJ_DELTA_FLD 7:4
`define MCSJ_RPT_FLD 3:0
// Serial clock burst length
`define MCSJ_BURST_LEN 5'h10
// Serial clock shape in ns, clock period in ns
`define MCSJ_SCLK_HI_NS 14
`define MCSJ_SCLK_LO_NS 7
`define MCSJ_CLK_NS 100
// Least times round up, at least one cycle
`define MCSJ_SCLK_HI_CYC 2'((`MCSJ_SCLK_HI_NS + `MCSJ_CLK_NS - 1) / `MCSJ_CLK_NS)
`define MCSJ_SCLK_LO_CYC 2'((`MCSJ_SCLK_LO_NS + `MCSJ_CLK_NS - 1) / `MCSJ_CLK_NS)
// Soft reset length in cycles
`define MCSJ_SRST_CYC 3'h4
`endif

// ### rtl/mcsj_pkg.sv
package mcsj_pkg;
  `include "mcsj_cfg.svh"

  // Register request from the serial port logic
  typedef struct packed {
    logic                     wr;
    logic [`MCSJ_ADDR_W-1:0]  addr;
    logic [`MCSJ_DATA_W-1:0]  wdata;
  } mcsj_req_s;

  // Master control register layout
  typedef struct packed {
    logic gpio_echo_enable;
    logic digital_loopback_enable;
    logic analog_loopback_enable;
    logic soft_reset_bit;
    logic oscillator_dac_powerdown;
    logic receive_powerdown;
    logic transmit_powerdown;
    logic soft_reference_powerdown;
  } mcsj_mctl_s;

  // Jitter sequencer states
  typedef enum logic [1:0] {
    JIT_IDLE,
    JIT_WAIT,
    JIT_RUN
  } mcsj_jit_e;
endpackage

// ### verif/mcsj_host_model.sv
`timescale 1ns/1ps
module mcsj_host_model (
  input  wire logic [7:0]          rd_data,
  input  wire logic                clk,
  output mcsj_pkg::mcsj_req_s      reg_req,
  output logic [1:0]               gpio_in,
  output logic                     dpll_mode_pin
);
  import mcsj_pkg::*;
  // Idle bus, pins low, VCXO mode
  initial begin
    reg_req = '0;
    gpio_in = 2'h0;
    dpll_mode_pin = 1'b0;
  end
  // One-cycle write strobe; released data is scrambled
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(posedge clk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.wdata = ~d;
  endtask
  // Address held one edge, registered data taken after it
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req.addr = a;
    @(posedge clk);
    #1;
    d = rd_data;
  endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "mcsj_cfg.svh"
module tb_top;
  import mcsj_pkg::*;
  logic       clk;
  logic       rst_b;
  mcsj_req_s  req;
  logic [1:0] gin;
  logic [1:0] gecho;
  logic       mode;
  logic       adc;
  logic       dac;
  logic       sclk;
  logic [7:0] rdat;
  logic [7:0] ctl;
  int         fail_count;
  int         n_compared;
  int         m[8][5];
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  mcsj_host_model host (.rd_data(rdat), .clk(clk), .reg_req(req), .gpio_in(gin),
    .dpll_mode_pin(mode));
  mcsj_top dut (.clk(clk), .rst_b(rst_b), .reg_req(req), .gpio_in(gin),
    .dpll_mode_pin(mode), .rd_data(rdat), .gpio_echo(gecho),
    .gpio_echo_enable(ctl[7]), .digital_loopback_enable(ctl[6]),
    .analog_loopback_enable(ctl[5]), .soft_reset(ctl[4]),
    .oscillator_dac_powerdown(ctl[3]), .receive_powerdown(ctl[2]),
    .transmit_powerdown(ctl[1]), .soft_reference_powerdown(ctl[0]),
    .adc_sample_clock(adc), .dac_sample_clock(dac), .serial_clk(sclk));
  // Compare and count
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // Verdict and stop
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Step to just after the next rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Stop at the first sample where the sample clock has risen
  task automatic wait_rise();
    logic p;
    p = adc;
    repeat (300) begin
      tick();
      if (p !== 1'b1 && adc === 1'b1) break;
      p = adc;
    end
  endtask
  // Per period: length, adc high, sclk rises, sclk high, dac rises
  task automatic meas(int n);
    logic ps;
    logic pd;
    logic pa;
    ps = 1'b0;
    pd = 1'b0;
    wait_rise();
    for (int i = 0; i < n; i++) begin
      m[i] = '{default: 0};
      do begin
        m[i][0]++;
        m[i][1] += int'(adc === 1'b1);
        m[i][2] += int'(sclk === 1'b1 && ps !== 1'b1);
        m[i][3] += int'(sclk === 1'b1);
        m[i][4] += int'(dac === 1'b1 && pd !== 1'b1);
        ps = sclk;
        pd = dac;
        pa = adc;
        tick();
      end while (!(pa !== 1'b1 && adc === 1'b1) && m[i][0] < 300);
    end
  endtask
  // Reset values, each control bit alone except soft reset (bit 4), echo of GPIO levels
  task automatic t_reg();
    logic [7:0] v;
    host.rd(`MCSJ_OFF_MCTL, v);
    chk("mctl_reset", v, `MCSJ_MCTL_RST);
    chk("ctl_reset", ctl, 8'h00);
    host.rd(5'h1F, v);
    chk("unmapped", v, 8'h00);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) begin
        host.wr(`MCSJ_OFF_MCTL, 8'h01 << i);
        host.rd(`MCSJ_OFF_MCTL, v);
        chk("mctl_rd", v, 8'h01 << i);
        chk("ctl", ctl, 8'h01 << i);
      end
    end
    host.gpio_in = 2'h2;
    repeat (5) tick();
    chk("echo_on", gecho, 2'h2);
    host.wr(`MCSJ_OFF_MCTL, 8'h00);
    repeat (3) tick();
    chk("echo_off", gecho, 2'h0);
  endtask
  // Soft reset length and self-clearing bit
  task automatic t_soft();
    logic [7:0] v;
    int n;
    host.wr(`MCSJ_OFF_MCTL, 8'h14);
    n = 0;
    while (ctl[4] === 1'b1 && n < 20) begin
      n++;
      tick();
    end
    chk("srst_len", n, `MCSJ_SRST_CYC);
    host.rd(`MCSJ_OFF_MCTL, v);
    chk("mctl_after", v, 8'h00);
  endtask
  // Period shape in digital loop mode, default then a rewritten ratio
  task automatic t_div();
    logic [7:0] v;
    host.rd(`MCSJ_OFF_DEF, v);
    chk("def_reset", v, `MCSJ_DEF_RST);
    meas(2);
    chk("period", m[1][0], `MCSJ_DEF_RST);
    chk("adc_high", m[1][1], `MCSJ_DEF_RST / 2);
    chk("dac_rises", m[1][4], 2);
    chk("sclk_rises", m[1][2], `MCSJ_BURST_LEN);
    chk("sclk_high", m[1][3], `MCSJ_BURST_LEN);
    host.wr(`MCSJ_OFF_DEF, 8'h30);
    host.rd(`MCSJ_OFF_DEF, v);
    chk("def_rd", v, 8'h30);
    meas(2);
    chk("period_48", m[1][0], 8'h30);
    chk("adc_high_48", m[1][1], 8'h18);
    chk("dac_rises_48", m[1][4], 2);
    host.wr(`MCSJ_OFF_DEF, `MCSJ_DEF_RST);
  endtask
  // Delay 2 after delta/repeat when wdly is set; periods 2..4 after the write's period (measured 1..3)
  task automatic t_jit(logic [7:0] dr, int dl, logic wdly);
    logic [7:0] v;
    host.wr(`MCSJ_OFF_DELTA, dr);
    host.rd(`MCSJ_OFF_DELTA, v);
    chk("delta_rd", v, dr);
    wait_rise();
    if (wdly) begin
      host.wr(`MCSJ_OFF_DELAY, 8'h02);
    end
    host.rd(`MCSJ_OFF_DELAY, v);
    chk("delay_rd", v, 8'h00);
    meas(6);
    for (int i = 0; i < 6; i++) begin
      chk("period", m[i][0], (i >= 1 && i <= 3) ? 64 + dl : 64);
      chk("dac_rises", m[i][4], 2);
    end
  endtask
  // VCXO mode: sample clock equals converter clock, period half the default ratio
  task automatic t_vcxo();
    host.dpll_mode_pin = 1'b0;
    repeat (300) tick();
    for (int i = 0; i < 16; i++) begin
      chk("adc_eq_dac", adc, dac);
      tick();
    end
    meas(2);
    chk("vcxo_period", m[1][0], `MCSJ_DEF_RST / 2);
  endtask
  // Stimulus
  initial begin
    rst_b = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    #1;
    chk("rd_in_reset", rdat, 8'h00);
    rst_b = 1'b1;
    repeat (3) tick();
    t_reg();
    t_soft();
    host.dpll_mode_pin = 1'b1;
    repeat (4) tick();
    t_div();
    t_jit(8'h13, 1, 1'b1);
    t_jit(8'h13, 0, 1'b0);
    t_jit(8'hF3, -1, 1'b1);
    t_jit(8'h03, 0, 1'b1);
    t_jit(8'h10, 0, 1'b1);
    t_vcxo();
    end_sim();
  end
  // Hang guard
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
endmodule
